// [src/actad_top.sv]
// module: actuator address assignment, button capture, led code, reset, rotation sense
// How it works
// [RL1] unaddressed actuator starts in addressing mode with led steadily lit
// [RL2] button press during pending assignment binds that address to this actuator
// [RL3] controller starts assignment on operator confirm, then prompts for the button
// [RL4] controller refuses a function already occupied and reports the conflict
// [RL5] once addressed the actuator reports its stored address by led blinks
// [RL6] each blink occupies a 200 ms interval
// [RL7] led stays dark 1.2 s between repetitions of the blink sequence; the code keeps it dark 1.3 s (100 ms off of the last blink plus the 1.2 s gap)
// [RL8] button held ten seconds in normal operation erases the stored address
// [RL9] after erasure the actuator returns to addressing mode, led steady on
// [RL10] rotation sense is standard (counterclockwise) or reversed (clockwise)
// [RL11] controller keeps rotation sense so a replacement inherits it
// [RL12] controller blocks rotation sense changes while curves or ignition points exist
// [RL13] home position move allowed only in fault-free standby
// [RL14] blinks per sequence equal the numeric address value
// [RL15] short press acts only in addressing mode with assignment pending
module actad_top #(
  parameter int unsigned TICK_CYC = actad_pkg::TICK_CYC,
  parameter int unsigned BLINK_MS = actad_pkg::BLINK_MS,
  parameter int unsigned GAP_MS   = actad_pkg::GAP_MS,
  parameter int unsigned LONG_MS  = actad_pkg::LONG_PRESS_MS
) (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic                        btn_n,
  input  actad_pkg::actad_assign_t         assign_in,
  input  actad_pkg::actad_rot_t            rot_in,
  input  wire logic                        home_cmd,
  input  wire logic                        standby_ok,
  input  actad_pkg::actad_addr_t           nv_in,
  output logic                             led_q,
  output actad_pkg::actad_addr_t           addr_q,
  output logic                             pending_q,
  output logic                             bound_q,
  output logic                             erased_q,
  output actad_pkg::actad_rot_sense_t      rotation_sense_setting_q,
  output logic                             home_go_q
);

  localparam logic [actad_pkg::CNT_W-1:0] TICK_L = actad_pkg::CNT_W'(TICK_CYC - 1);
  localparam logic [actad_pkg::CNT_W-1:0] LONG_L = actad_pkg::CNT_W'(LONG_MS - 1);

  logic [1:0]                    rst_sync_q;
  logic                          rst_n;
  logic                          btn_meta_q;
  logic                          btn_q;
  logic                          btn_prev_q;
  logic                          press_edge;
  logic [actad_pkg::CNT_W-1:0]   tick_cnt_q;
  logic                          tick_q;
  logic [actad_pkg::CNT_W-1:0]   hold_q;
  logic                          long_hit;
  logic                          init_q;
  logic [actad_pkg::ADDR_W-1:0]  pend_addr_q;
  logic                          bind_now;
  logic                          blink_led;
  actad_pkg::actad_state_t       state_q;

  // ==========================================================================
  // reset release and button synchroniser
  // ==========================================================================
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      btn_meta_q <= 1'b0;
      btn_q      <= 1'b0;
      btn_prev_q <= 1'b0;
    end else begin
      btn_meta_q <= ~btn_n;
      btn_q      <= btn_meta_q;
      btn_prev_q <= btn_q;
    end
  end
  assign press_edge = btn_q & ~btn_prev_q;

  // ==========================================================================
  // millisecond tick
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == TICK_L) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q     <= 1'b0;
    end
  end

  // ==========================================================================
  // long press timer
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= '0;
    end else if (!btn_q) begin
      hold_q <= '0;
    end else if (tick_q && hold_q != LONG_L) begin
      hold_q <= hold_q + 1'b1;
    end
  end
  // fires once: the counter saturates and the state has left normal mode
  assign long_hit = (state_q == actad_pkg::ST_NORMAL) && btn_q && tick_q
                    && (hold_q == LONG_L); // see [RL8]

  // ==========================================================================
  // pending assignment
  // ==========================================================================
  assign bind_now = (state_q == actad_pkg::ST_ADDRESSING) && pending_q && press_edge;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_q   <= 1'b0;
      pend_addr_q <= actad_pkg::ADDR_RST;
    end else if (assign_in.start && state_q == actad_pkg::ST_ADDRESSING) begin
      // a new start wins over a cancel in the same cycle; a bind in that cycle still binds the old pend_addr_q
      pending_q   <= 1'b1;
      pend_addr_q <= assign_in.addr;
    end else if (assign_in.cancel || bind_now || state_q != actad_pkg::ST_ADDRESSING) begin
      pending_q   <= 1'b0;
    end
  end

  // ==========================================================================
  // addressing state
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= actad_pkg::ST_ADDRESSING; // see [RL1]
      addr_q   <= '0;
      init_q   <= 1'b0;
      bound_q  <= 1'b0;
      erased_q <= 1'b0;
    end else begin
      bound_q  <= 1'b0;
      erased_q <= 1'b0;
      if (!init_q) begin
        init_q <= 1'b1;
        if (nv_in.valid) begin
          addr_q  <= nv_in;
          state_q <= actad_pkg::ST_NORMAL;
        end
      end else begin
        case (state_q)
          actad_pkg::ST_ADDRESSING: begin
            if (bind_now) begin // see [RL2] see [RL15]
              addr_q.addr  <= pend_addr_q;
              addr_q.valid <= 1'b1;
              bound_q      <= 1'b1;
              state_q      <= actad_pkg::ST_NORMAL;
            end
          end
          actad_pkg::ST_NORMAL: begin
            if (long_hit) begin // see [RL8] see [RL9]
              addr_q   <= '0;
              erased_q <= 1'b1;
              state_q  <= actad_pkg::ST_ADDRESSING;
            end
          end
          default: begin
            state_q <= actad_pkg::ST_ADDRESSING;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // led drive
  // ==========================================================================
  actad_blink #(
    .BLINK_MS (BLINK_MS),
    .GAP_MS   (GAP_MS)
  ) u_blink (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick_q),
    .run   (state_q == actad_pkg::ST_NORMAL),
    .count (addr_q.addr),
    .led_q (blink_led)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_q <= 1'b1;
    end else begin
      led_q <= (state_q == actad_pkg::ST_ADDRESSING) ? 1'b1 : blink_led; // see [RL1] see [RL5]
    end
  end

  // ==========================================================================
  // rotation sense and home move
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rotation_sense_setting_q <= actad_pkg::ROT_STANDARD;
    end else if (rot_in.wr) begin
      rotation_sense_setting_q <= rot_in.sense; // see [RL10]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      home_go_q <= 1'b0;
    end else begin
      home_go_q <= home_cmd && standby_ok; // see [RL13]
    end
  end

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_addr_led;
    state_q == actad_pkg::ST_ADDRESSING |=> led_q;
  endproperty
  a_addr_led: assert property (p_addr_led) else $error("led not steady in addressing"); // see [RL1]

  property p_bind;
    bind_now && init_q |=> addr_q.valid && addr_q.addr == $past(pend_addr_q) && bound_q
                           && state_q == actad_pkg::ST_NORMAL ##1 led_q == blink_led;
  endproperty
  a_bind: assert property (p_bind) else $error("press did not bind address"); // see [RL2]

  property p_no_bind;
    init_q && state_q == actad_pkg::ST_ADDRESSING && !pending_q |=>
      state_q == actad_pkg::ST_ADDRESSING && !bound_q;
  endproperty
  a_no_bind: assert property (p_no_bind) else $error("press acted without pending"); // see [RL15]

  property p_erase;
    long_hit && init_q |=> state_q == actad_pkg::ST_ADDRESSING && !addr_q.valid && erased_q
                           ##1 led_q;
  endproperty
  a_erase: assert property (p_erase) else $error("long press did not erase"); // see [RL8]

  property p_short_keeps;
    init_q && state_q == actad_pkg::ST_NORMAL && hold_q != LONG_L |=>
      state_q == actad_pkg::ST_NORMAL && addr_q == $past(addr_q);
  endproperty
  a_short_keeps: assert property (p_short_keeps) else $error("address lost early"); // see [RL15]

  property p_erase_led;
    erased_q |-> ##1 led_q [*2];
  endproperty
  a_erase_led: assert property (p_erase_led) else $error("led not steady after erase"); // see [RL9]

  property p_rot;
    rot_in.wr |=> rotation_sense_setting_q == $past(rot_in.sense);
  endproperty
  a_rot: assert property (p_rot) else $error("rotation sense not stored"); // see [RL10]

  property p_home;
    home_go_q |-> $past(standby_ok) && $past(home_cmd);
  endproperty
  a_home: assert property (p_home) else $error("home move outside standby"); // see [RL13]

  c_bind: cover property (bind_now);
  c_erase: cover property (long_hit);
  c_home: cover property (home_go_q);
  c_blink: cover property (state_q == actad_pkg::ST_NORMAL && $rose(led_q));

endmodule // actad_top

// [src/actad_pkg.sv]
// package: constants and types for the actuator address assignment block
package actad_pkg;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned TICK_MS       = 1;
  localparam int unsigned TICK_CYC      = CLK_HZ / MS_PER_S * TICK_MS;
  localparam int unsigned BLINK_MS      = 200;
  localparam int unsigned GAP_MS        = 1200;
  localparam int unsigned LONG_PRESS_S  = 10;
  localparam int unsigned LONG_PRESS_MS = LONG_PRESS_S * MS_PER_S;
  localparam int unsigned CNT_W         = 16;

  // ==========================================================================
  // widths and reset values
  // ==========================================================================
  localparam int unsigned ADDR_W        = 4;
  localparam logic [3:0]  ADDR_RST      = 4'h0;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [1:0] {
    ST_ADDRESSING = 2'h1,
    ST_NORMAL     = 2'h2
  } actad_state_t;

  typedef enum logic [2:0] {
    BL_ON  = 3'h1,
    BL_OFF = 3'h2,
    BL_GAP = 3'h4
  } actad_phase_t;

  typedef enum logic {
    ROT_STANDARD = 1'b0,
    ROT_REVERSED = 1'b1
  } actad_rot_sense_t;

  typedef struct packed {
    logic              start;
    logic              cancel;
    logic [ADDR_W-1:0] addr;
  } actad_assign_t;

  typedef struct packed {
    logic             wr;
    actad_rot_sense_t sense;
  } actad_rot_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } actad_addr_t;

endpackage

// [src/actad_blink.sv]
// module: led blink code generator, one blink per address unit then a dark gap
module actad_blink #(
  parameter int unsigned BLINK_MS = actad_pkg::BLINK_MS,
  parameter int unsigned GAP_MS   = actad_pkg::GAP_MS
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          tick,
  input  wire logic                          run,
  input  wire logic [actad_pkg::ADDR_W-1:0]  count,
  output logic                               led_q
);

  localparam int unsigned ON_MS  = BLINK_MS / 2;
  localparam int unsigned OFF_MS = BLINK_MS - ON_MS;
  localparam logic [actad_pkg::CNT_W-1:0] ON_L  = actad_pkg::CNT_W'(ON_MS - 1);
  localparam logic [actad_pkg::CNT_W-1:0] OFF_L = actad_pkg::CNT_W'(OFF_MS - 1);
  localparam logic [actad_pkg::CNT_W-1:0] GAP_L = actad_pkg::CNT_W'(GAP_MS - 1);

  actad_pkg::actad_phase_t             phase_q;
  logic [actad_pkg::CNT_W-1:0]         ms_q;
  logic [actad_pkg::ADDR_W-1:0]        n_q;

  // ==========================================================================
  // sequencer
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= actad_pkg::BL_GAP;
      ms_q    <= '0;
      n_q     <= '0;
      led_q   <= 1'b0;
    end else if (!run) begin
      phase_q <= actad_pkg::BL_GAP;
      ms_q    <= '0;
      n_q     <= '0;
      led_q   <= 1'b0;
    end else if (tick) begin
      case (phase_q)
        actad_pkg::BL_ON: begin
          if (ms_q == ON_L) begin // see [RL6]
            ms_q    <= '0;
            phase_q <= actad_pkg::BL_OFF;
            led_q   <= 1'b0;
          end else begin
            ms_q <= ms_q + 1'b1;
          end
        end
        actad_pkg::BL_OFF: begin
          if (ms_q == OFF_L) begin // see [RL6]
            ms_q <= '0;
            if (n_q + 1'b1 == count) begin // see [RL14]
              n_q     <= '0;
              phase_q <= actad_pkg::BL_GAP;
            end else begin
              n_q     <= n_q + 1'b1;
              phase_q <= actad_pkg::BL_ON;
              led_q   <= 1'b1;
            end
          end else begin
            ms_q <= ms_q + 1'b1;
          end
        end
        actad_pkg::BL_GAP: begin
          if (ms_q == GAP_L) begin // see [RL7]
            ms_q <= '0;
            if (count != '0) begin
              phase_q <= actad_pkg::BL_ON;
              led_q   <= 1'b1;
            end
          end else begin
            ms_q <= ms_q + 1'b1;
          end
        end
        default: begin
          phase_q <= actad_pkg::BL_GAP;
          ms_q    <= '0;
          led_q   <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // assertions
  // ==========================================================================
  logic [actad_pkg::CNT_W-1:0]  on_len_q;
  logic [actad_pkg::ADDR_W-1:0] rise_cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_len_q <= '0;
    end else if (!led_q) begin
      on_len_q <= '0;
    end else if (tick) begin
      on_len_q <= on_len_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_cnt_q <= '0;
    end else if (phase_q == actad_pkg::BL_GAP) begin
      rise_cnt_q <= '0;
    end else if ($rose(led_q)) begin
      rise_cnt_q <= rise_cnt_q + 1'b1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_on_width;
    $fell(led_q) && run && $past(run) |-> on_len_q == actad_pkg::CNT_W'(ON_MS);
  endproperty
  a_on_width: assert property (p_on_width) else $error("blink on time wrong"); // see [RL6]

  property p_gap_dark;
    phase_q == actad_pkg::BL_GAP |-> !led_q;
  endproperty
  a_gap_dark: assert property (p_gap_dark) else $error("led lit during gap"); // see [RL7]

  property p_blink_count;
    run && $past(run) && $rose(phase_q == actad_pkg::BL_GAP) |-> rise_cnt_q == count;
  endproperty
  a_blink_count: assert property (p_blink_count) else $error("blink count wrong"); // see [RL14]

  c_sequence_done: cover property (run && $rose(phase_q == actad_pkg::BL_GAP));

endmodule // actad_blink

// [sim/actad_ctrl_model.sv]
// controller stand-in: delayed assignment start, duplicate refusal, rotation store, home gate
module actad_ctrl_model #(
  parameter int unsigned DELAY = 3
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          confirm,
  input  wire logic                          cancel_req,
  input  wire logic [actad_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic                          bound,
  input  wire logic                          rot_req,
  input  wire logic                          rot_val,
  input  wire logic                          curves_exist,
  input  wire logic                          home_req,
  input  wire logic                          fault,
  output actad_pkg::actad_assign_t           assign_o,
  output actad_pkg::actad_rot_t              rot_o,
  output logic                               home_cmd,
  output logic                               standby_ok,
  output logic                               conflict_q,
  output logic                               sense_q
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [15:0]                  used_q;
  logic [3:0]                   dly_q;
  logic [actad_pkg::ADDR_W-1:0] tgt_q;
  logic                         start_q;
  logic                         cancel_q;
  logic                         wr_q;

  // ==========================================================================
  // assignment
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      used_q     <= 16'h0000;
      dly_q      <= 4'h0;
      tgt_q      <= 4'h0;
      start_q    <= 1'b0;
      cancel_q   <= 1'b0;
      conflict_q <= 1'b0;
    end else begin
      start_q    <= 1'b0;
      conflict_q <= 1'b0;
      cancel_q   <= cancel_req;
      if (confirm && used_q[req_addr]) begin
        conflict_q <= 1'b1;
      end else if (confirm) begin
        dly_q <= 4'(DELAY);
        tgt_q <= req_addr;
      end else if (dly_q != 4'h0) begin
        dly_q   <= dly_q - 4'h1;
        start_q <= (dly_q == 4'h1);
      end
      if (bound) begin
        used_q[tgt_q] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // rotation sense, kept here and locked while curves exist
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q    <= 1'b0;
      sense_q <= 1'b0;
    end else begin
      wr_q <= rot_req && !curves_exist;
      if (rot_req && !curves_exist) begin
        sense_q <= rot_val;
      end
    end
  end

  assign assign_o   = '{start: start_q, cancel: cancel_q, addr: tgt_q};
  assign rot_o      = '{wr: wr_q, sense: actad_pkg::actad_rot_sense_t'(sense_q)};
  assign home_cmd   = home_req;
  assign standby_ok = ~fault;
endmodule // actad_ctrl_model

// [sim/actad_top_bench.sv]
// testbench: actuator address assignment against the controller model
module actad_top_bench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int ON_CYC  = 2 * 4;
  localparam int GAP_CYC = 6 * 4;

  logic clk, rstn, btn_n, confirm, cancel_req, rot_req, rot_val, curves_exist, home_req, fault;
  logic                        home_cmd, standby_ok, conflict_q, sense_q;
  logic                        led_q, pending_q, bound_q, erased_q, home_go_q;
  logic [3:0]                  req_addr;
  actad_pkg::actad_assign_t    assign_s;
  actad_pkg::actad_rot_t       rot_s;
  actad_pkg::actad_addr_t      nv_in;
  actad_pkg::actad_addr_t      addr_q;
  actad_pkg::actad_rot_sense_t rot_sense;
  int                          bad_count;
  int                          num_checks;

  actad_ctrl_model ctrl (.clk(clk), .rst_n(rstn), .confirm(confirm), .cancel_req(cancel_req),
    .req_addr(req_addr), .bound(bound_q), .rot_req(rot_req), .rot_val(rot_val),
    .curves_exist(curves_exist), .home_req(home_req), .fault(fault), .assign_o(assign_s),
    .rot_o(rot_s), .home_cmd(home_cmd), .standby_ok(standby_ok), .conflict_q(conflict_q),
    .sense_q(sense_q));

  actad_top #(.TICK_CYC(4), .BLINK_MS(4), .GAP_MS(6), .LONG_MS(20)) dut (.clk(clk),
    .rstn(rstn), .btn_n(btn_n), .assign_in(assign_s), .rot_in(rot_s), .home_cmd(home_cmd),
    .standby_ok(standby_ok), .nv_in(nv_in), .led_q(led_q), .addr_q(addr_q),
    .pending_q(pending_q), .bound_q(bound_q), .erased_q(erased_q),
    .rotation_sense_setting_q(rot_sense), .home_go_q(home_go_q));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================================
  // helpers
  // ==========================================================================
  task step();
    @(posedge clk);
    #2;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task chk_n(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task wait_sig(input int sel, input int lim);
    int   i;
    logic s;
    for (i = 0; i < lim; i++) begin
      case (sel)
        0: s = pending_q;
        1: s = bound_q;
        2: s = erased_q;
        default: s = conflict_q;
      endcase
      if (s === 1'b1) break;
      step();
    end
    if (i == lim) begin
      bad_count++;
      $display("[ERR] t=%0t wait %h got=%h exp=%h", $time, sel, 0, 1);
      tally_and_finish();
    end
  endtask

  task run_len(input logic v, output int n);
    n = 0;
    while (led_q === v && n < 400) begin
      step();
      n++;
    end
    if (n == 400) begin
      bad_count++;
      $display("[ERR] t=%0t led stuck got=%h exp=%h", $time, v, ~v);
      tally_and_finish();
    end
  endtask

  // blink count, first on length and dark run after the last blink
  task led_code(output int nb, output int on_len, output int dark);
    int n;
    nb = 0;
    on_len = 0;
    dark = 0;
    for (int k = 0; k < 30; k++) begin
      run_len(1'b0, n);
      if (n > 2 * ON_CYC) break;
      run_len(1'b1, n);
    end
    for (int k = 0; k < 20; k++) begin
      run_len(1'b1, n);
      if (nb == 0) on_len = n;
      nb++;
      run_len(1'b0, n);
      if (n > 2 * ON_CYC) begin
        dark = n;
        break;
      end
    end
  endtask

  task steady_led(input logic v, input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      step();
      if (led_q !== v) ok = 1'b0;
    end
    chk(ok, 8'h01);
  endtask

  task ask(input logic [3:0] a);
    confirm = 1'b1;
    req_addr = a;
    step();
    confirm = 1'b0;
  endtask

  task rot(input logic v);
    rot_req = 1'b1;
    rot_val = v;
    step();
    rot_req = 1'b0;
    repeat (3) step();
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task t_bind(input logic [3:0] a);
    int nb, on_len, dark;
    ask(a);
    wait_sig(0, 20);
    chk(pending_q, 8'h01);
    btn_n = 1'b0;
    wait_sig(1, 10);
    btn_n = 1'b1;
    chk({3'h0, addr_q}, {3'h0, 1'b1, a});
    chk(pending_q, 8'h00);
    led_code(nb, on_len, dark);
    chk_n(nb, int'(a));
    chk_n(on_len, ON_CYC);
    chk_n(dark, ON_CYC + GAP_CYC);
    $display("test bind %0d done", a);
  endtask

  task t_erase();
    btn_n = 1'b0;
    repeat (40) step();
    btn_n = 1'b1;
    repeat (4) step();
    chk({3'h0, addr_q}, 8'h11);
    btn_n = 1'b0;
    wait_sig(2, 200);
    chk({3'h0, addr_q}, 8'h00);
    btn_n = 1'b1;
    repeat (2) step();
    steady_led(1'b1, 40);
    $display("test erase done");
  endtask

  task t_refusals();
    ask(4'h1);
    wait_sig(3, 10);
    repeat (6) step();
    chk(pending_q, 8'h00);
    ask(4'h5);
    wait_sig(0, 20);
    cancel_req = 1'b1;
    step();
    cancel_req = 1'b0;
    repeat (3) step();
    chk(pending_q, 8'h00);
    btn_n = 1'b0;
    repeat (6) step();
    btn_n = 1'b1;
    chk({3'h0, addr_q}, 8'h00);
    $display("test refusals done");
  endtask

  task t_rot_home();
    rot(1'b1);
    chk(rot_sense, 8'h01);
    rot(1'b0);
    chk(rot_sense, 8'h00);
    rot(1'b1);
    curves_exist = 1'b1;
    rot(1'b0);
    chk(rot_sense, 8'h01);
    chk(sense_q, 8'h01);
    fault = 1'b1;
    home_req = 1'b1;
    repeat (2) step();
    chk(home_go_q, 8'h00);
    fault = 1'b0;
    step();
    chk(home_go_q, 8'h01);
    home_req = 1'b0;
    step();
    chk(home_go_q, 8'h00);
    $display("test rotation and home done");
  endtask

  // mid-run reset with a stored address: must come back addressed, led dark at the start of the first gap
  task t_restore();
    nv_in = addr_q;
    rstn = 1'b0;
    repeat (2) step();
    rstn = 1'b1;
    chk(led_q, 8'h01);
    repeat (4) step();
    chk({3'h0, addr_q}, {3'h0, nv_in});
    steady_led(1'b0, 16);
    $display("test restore done");
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("[ERR] t=%0t run limit got=%h exp=%h", $time, 0, 1);
    tally_and_finish();
  end

  initial begin
    {rstn, confirm, cancel_req, rot_req, rot_val, curves_exist, home_req, fault} = 8'h00;
    btn_n = 1'b1;
    req_addr = 4'h0;
    nv_in = '0;
    bad_count = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    #2 rstn = 1'b1;
    repeat (6) step();
    chk({3'h0, addr_q}, 8'h00);
    steady_led(1'b1, 40);
    btn_n = 1'b0;
    repeat (10) step();
    btn_n = 1'b1;
    repeat (3) step();
    chk({3'h0, addr_q}, 8'h00);
    $display("test idle done");
    t_bind(4'h1);
    t_erase();
    t_refusals();
    t_bind(4'hF);
    t_restore();
    t_rot_home();
    tally_and_finish();
  end
endmodule // actad_top_bench
